// >>> design/crc_core.sv
// register control-state decoder and datapath behind an ahb-lite slave
// assumes a single ahb master, whole-word single transfers, and that the
// memory array logic reports next free address and match state
`timescale 1ns/1ps
module crc_core
    import crc_pkg::*;
#(
    parameter int FREE_W = 13
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic full_flag_n,
    output logic [15:0] page_array_addr_out
);
    logic [7:0] addr_q;
    logic wr_ph_q;
    logic rd_ph_q;
    logic [31:0] hrdata_q;
    logic hready_q;
    logic hresp_q;
    logic [31:0] data_bus_q;
    logic [31:0] dq_out_q;
    logic rsp_q;
    logic [31:0] ptr_q;
    logic [31:0] cfg_q;
    logic [31:0] csel_q;
    logic [63:0] key_q;
    logic [31:0] arr_q;
    logic [31:0] casc_q;
    logic [15:0] pa_q;

    logic exec;
    logic [5:0] fn;
    logic [2:0] msel;
    logic rd_line;
    logic seg;
    logic selected;
    logic nfa_resp;
    logic stat_resp;
    logic [3:0] page;
    logic [31:0] m;
    logic rd_hit;
    logic [31:0] rd_val;
    logic wr_ok;
    logic [31:0] bus_mux;

    crc_mask_if mif ();

    crc_mask_bank u_bank (
        .hclk(hclk),
        .hresetn(hresetn),
        .mif(mif.bank)
    );

    // ahb-lite slave: writes take no wait state, reads one, so that a
    // read right behind a command write sees its result
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            wr_ph_q <= 1'b0;
            rd_ph_q <= 1'b0;
        end else begin
            wr_ph_q <= 1'b0;
            rd_ph_q <= 1'b0;
            if (hsel && hready && htrans[1]) begin
                addr_q <= haddr[7:0];
                wr_ph_q <= hwrite;
                rd_ph_q <= !hwrite;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hready_q <= 1'b1;
            hrdata_q <= RST_WORD;
            hresp_q <= 1'b0;
        end else begin
            hready_q <= 1'b1;
            if (hsel && hready && htrans[1] && !hwrite) begin
                hready_q <= 1'b0;
            end
            if (rd_ph_q) begin
                hrdata_q <= bus_mux;
            end
        end
    end

    always_comb begin
        case (addr_q)
            OFF_DQ_IN: bus_mux = data_bus_q;
            OFF_DQ_OUT: bus_mux = dq_out_q;
            OFF_RESP: bus_mux = {31'h0, rsp_q};
            OFF_ARRAY: bus_mux = arr_q;
            OFF_CASC: bus_mux = casc_q;
            default: bus_mux = 32'h0000_0000;
        endcase
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp = hresp_q;

    // control code decode straight from the write data phase
    assign exec = wr_ph_q && addr_q == OFF_CTRL;
    assign fn = hwdata[CODE_FN_LSB +: 6];
    assign msel = hwdata[CODE_SEL_LSB +: 3];
    assign rd_line = hwdata[CTRL_RD_BIT];
    assign seg = hwdata[CTRL_SEG_BIT];
    // direct memory access (valid strobe low) is not ours to handle
    assign wr_ok = exec && hwdata[CTRL_AVN_BIT];

    assign page = cfg_q[CFG_PAGE_LSB +: 4];
    assign selected = csel_q[3:0] == page;
    assign nfa_resp = !casc_q[CASC_FULLIN_BIT] &&
        arr_q[ARR_FULLN_BIT];

    always_comb begin
        case (arr_q[ARR_KIND_LSB +: 2])
            KIND_MATCH: stat_resp =
                (arr_q[ARR_MATCH_BIT] && !casc_q[CASC_HIGHER_BIT]) ||
                (!casc_q[CASC_ANY_BIT] && casc_q[CASC_LOWEST_BIT]);
            KIND_RAND: stat_resp = selected;
            default: stat_resp = selected;
        endcase
    end

    // segment only matters for the 64-bit registers; the 32-bit ones
    // always use the low mask half
    assign mif.sel = msel;
    assign mif.seg = seg && (fn == FN_KEY || fn == FN_MASK);
    assign mif.wdata = data_bus_q;
    assign mif.we = wr_ok && !rd_line && fn == FN_MASK && selected;
    assign m = mif.rd_half;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [31:0] mk);
        merge = (old_v & mk) | (new_v & ~mk);
    endfunction : merge

    always_comb begin
        rd_hit = 1'b0;
        rd_val = 32'h0000_0000;
        case (fn)
            FN_NOP_NFA: begin
                rd_hit = nfa_resp;
                rd_val[PAGE_LSB +: 4] = page;
                rd_val[FREE_W-1:0] = arr_q[FREE_W-1:0];
            end
            FN_PTR: begin
                rd_hit = selected;
                rd_val = ptr_q;
            end
            FN_CFG: begin
                rd_hit = selected;
                rd_val = cfg_q;
            end
            FN_CSEL: begin
                rd_hit = selected;
                rd_val = csel_q;
            end
            FN_STAT: begin
                rd_hit = stat_resp;
                rd_val = {28'h0, arr_q[ARR_KIND_LSB +: 2],
                    !arr_q[ARR_FULLN_BIT], arr_q[ARR_MATCH_BIT]};
            end
            FN_KEY: begin
                rd_hit = selected;
                rd_val = seg ? key_q[63:32] : key_q[31:0];
            end
            FN_MASK: begin
                rd_hit = selected;
                rd_val = m;
            end
            default: begin
                rd_hit = 1'b0;
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // read answer: devices that do not answer keep the old word and flag no answer;
    // a nop (write line low) reaches no process at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_q <= 1'b0;
            dq_out_q <= RST_WORD;
        end else if (wr_ok && rd_line) begin
            rsp_q <= rd_hit;
            if (rd_hit) begin
                dq_out_q <= rd_val;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_bus_q <= RST_WORD;
        end else if (wr_ph_q && addr_q == OFF_DQ_IN) begin
            data_bus_q <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_q <= RST_WORD;
        end else if (wr_ok && !rd_line && fn == FN_PTR && selected) begin
            ptr_q <= merge(ptr_q, data_bus_q, m);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= RST_WORD;
        end else if (wr_ok && !rd_line && fn == FN_CFG && selected) begin
            cfg_q <= merge(cfg_q, data_bus_q, m);
        end
    end

    // chip select is written regardless of selection, otherwise a
    // device once deselected could never be reached again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csel_q <= RST_WORD;
        end else if (wr_ok && !rd_line && fn == FN_CSEL) begin
            csel_q <= merge(csel_q, data_bus_q, m);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_q <= {RST_WORD, RST_WORD};
        end else if (wr_ok && !rd_line && fn == FN_KEY && selected) begin
            if (seg) begin
                key_q[63:32] <= merge(key_q[63:32], data_bus_q, m);
            end else begin
                key_q[31:0] <= merge(key_q[31:0], data_bus_q, m);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arr_q <= RST_ARRAY;
            casc_q <= RST_CASC;
        end else if (wr_ph_q && addr_q == OFF_ARRAY) begin
            arr_q <= hwdata;
        end else if (wr_ph_q && addr_q == OFF_CASC) begin
            casc_q <= hwdata;
        end
    end

    // these control states never move the page/array address output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_q <= RST_PA;
        end else begin
            pa_q <= pa_q;
        end
    end

    assign full_flag_n = arr_q[ARR_FULLN_BIT];
    assign page_array_addr_out = pa_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_cmd(logic [5:0] f, logic r);
        wr_ok && fn == f && rd_line == r;
    endsequence

    chk_nop_no_change: assert property (s_cmd(FN_NOP_NFA, 1'b0)
        |=> $stable(ptr_q) && $stable(cfg_q) && $stable(csel_q) &&
            $stable(key_q) && $stable(dq_out_q) && $stable(rsp_q))
        else $error("nop changed state");
    chk_free_slot_word: assert property (s_cmd(FN_NOP_NFA, 1'b1)
        ##0 nfa_resp |=> rsp_q && dq_out_q[31:20] == 12'h000 &&
            dq_out_q[19:16] == $past(page) &&
            dq_out_q[FREE_W-1:0] == $past(arr_q[FREE_W-1:0]))
        else $error("next free read word wrong");
    chk_free_slot_scope: assert property (s_cmd(FN_NOP_NFA, 1'b1)
        ##0 !nfa_resp |=> !rsp_q && $stable(dq_out_q))
        else $error("wrong device answered next free read");
    chk_ptr_masked: assert property (s_cmd(FN_PTR, 1'b0)
        ##0 selected |=> ptr_q == (($past(ptr_q) & $past(m)) |
            ($past(data_bus_q) & ~$past(m))))
        else $error("pointer masked write wrong");
    chk_cfg_readback: assert property (s_cmd(FN_CFG, 1'b1)
        ##0 selected |=> rsp_q && dq_out_q == $past(cfg_q))
        else $error("config read wrong");
    chk_stat_scope: assert property (s_cmd(FN_STAT, 1'b1)
        ##0 arr_q[19:18] == KIND_MATCH |=> rsp_q == $past(
            (arr_q[ARR_MATCH_BIT] && !casc_q[CASC_HIGHER_BIT]) ||
            (!casc_q[CASC_ANY_BIT] && casc_q[CASC_LOWEST_BIT])))
        else $error("status responder wrong");
    chk_key_half_read: assert property (s_cmd(FN_KEY, 1'b1)
        ##0 selected |=> dq_out_q == ($past(seg) ? $past(key_q[63:32])
            : $past(key_q[31:0])))
        else $error("search key half read wrong");
    chk_key_other_half: assert property (s_cmd(FN_KEY, 1'b0)
        ##0 seg |=> $stable(key_q[31:0]))
        else $error("high key write touched low half");
    chk_pa_unchanged: assert property (wr_ok ##1 1'b1
        |-> $stable(page_array_addr_out))
        else $error("page/array address moved");
    chk_read_wait: assert property (hsel && hready && htrans[1] &&
        !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
endmodule : crc_core

// >>> inc/crc_pkg.sv
// constants for the register control-state decoder of a cascadable cam
// assumes one 200 MHz clock and an ahb-lite register slave in front
package crc_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DQ_IN = 8'h04;
    localparam logic [7:0] OFF_DQ_OUT = 8'h08;
    localparam logic [7:0] OFF_RESP = 8'h0C;
    localparam logic [7:0] OFF_ARRAY = 8'h10;
    localparam logic [7:0] OFF_CASC = 8'h14;
    localparam int CODE_FN_LSB = 0;
    localparam int CODE_SEL_LSB = 6;
    localparam int CTRL_RD_BIT = 12;
    localparam int CTRL_SEG_BIT = 13;
    localparam int CTRL_AVN_BIT = 14;
    localparam logic [5:0] FN_NOP_NFA = 6'h03;
    localparam logic [5:0] FN_PTR = 6'h04;
    localparam logic [5:0] FN_KEY = 6'h05;
    localparam logic [5:0] FN_CFG = 6'h06;
    localparam logic [5:0] FN_STAT = 6'h07;
    localparam logic [5:0] FN_CSEL = 6'h08;
    localparam logic [5:0] FN_MASK = 6'h09;
    localparam int ARR_FULLN_BIT = 16;
    localparam int ARR_MATCH_BIT = 17;
    localparam int ARR_KIND_LSB = 18;
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_MATCH = 2'h1;
    localparam logic [1:0] KIND_RAND = 2'h2;
    localparam int CASC_FULLIN_BIT = 0;
    localparam int CASC_HIGHER_BIT = 1;
    localparam int CASC_ANY_BIT = 2;
    localparam int CASC_LOWEST_BIT = 3;
    localparam int CFG_PAGE_LSB = 0;
    localparam int PAGE_LSB = 16;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_ARRAY = 32'h0001_0000;
    localparam logic [31:0] RST_CASC = 32'h0000_0009;
    localparam logic [15:0] RST_PA = 16'hFFFF;
endpackage : crc_pkg

// >>> inc/crc_mask_if.sv
// carrier between the decoder and the bit mask bank
// assumes both ends sit in the hclk domain
`timescale 1ns/1ps
interface crc_mask_if;
    logic we;
    logic [2:0] sel;
    logic seg;
    logic [31:0] wdata;
    logic [31:0] rd_half;
    modport ctl (output we, output sel, output seg, output wdata,
        input rd_half);
    modport bank (input we, input sel, input seg, input wdata,
        output rd_half);
endinterface : crc_mask_if

// >>> design/crc_mask_bank.sv
// seven 64-bit bit mask registers, written and read by halves
// assumes writes arrive already gated by device selection
`timescale 1ns/1ps
module crc_mask_bank
    import crc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    crc_mask_if.bank mif
);
    logic [63:0] mask_q [1:7];

    genvar gi;
    generate
        for (gi = 1; gi < 8; gi++) begin : g_mask
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mask_q[gi] <= {RST_WORD, RST_WORD};
                end else if (mif.we && mif.sel == 3'(gi)) begin
                    if (mif.seg) begin
                        mask_q[gi][63:32] <= mif.wdata;
                    end else begin
                        mask_q[gi][31:0] <= mif.wdata;
                    end
                end
            end
        end
    endgenerate

    // select 000 reads as zero, so it also means "no mask" upstream
    always_comb begin
        mif.rd_half = 32'h0000_0000;
        if (mif.sel != 3'h0) begin
            mif.rd_half = mif.seg ? mask_q[mif.sel][63:32]
                                  : mask_q[mif.sel][31:0];
        end
    end

    chk_sel0_nowrite: assert property (@(posedge hclk)
        disable iff (!hresetn)
        mif.we && mif.sel == 3'h0 |=> $stable(mask_q[1]) &&
            $stable(mask_q[7]))
        else $error("mask changed by select zero write");
    chk_mask_readback: assert property (@(posedge hclk)
        disable iff (!hresetn)
        mif.we && mif.sel != 3'h0 |=> ($past(mif.seg) ?
            mask_q[$past(mif.sel)][63:32] : mask_q[$past(mif.sel)][31:0])
            == $past(mif.wdata))
        else $error("mask half not written");
endmodule : crc_mask_bank

// >>> bench/crc_ctrl_model.sv
// controller model: an ahb-lite master that issues register control states
// assumes one slave whose hreadyout is fed back to it as hready
`timescale 1ns/1ps
module crc_ctrl_model
    import crc_pkg::*;
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // no wait count is assumed; only the bench timeout ends a stall
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        // released data must not keep showing the old word
        hwdata <= ~d;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0000_0000, r);
    endtask : rd

    task automatic cmd(input logic [5:0] fn, input logic [2:0] nnn,
        input logic rdl, input logic seg, input logic [31:0] dq);
        logic [31:0] c;
        c = 32'h0000_0000;
        c[CTRL_AVN_BIT] = 1'b1;
        c[CODE_SEL_LSB +: 3] = nnn;
        c[CODE_FN_LSB +: 6] = fn;
        c[CTRL_RD_BIT] = rdl;
        // segment may be high only in the two 64-bit states
        c[CTRL_SEG_BIT] = seg & (fn == FN_KEY || fn == FN_MASK);
        wr(OFF_DQ_IN, dq);
        wr(OFF_CTRL, c);
    endtask : cmd
endmodule : crc_ctrl_model

// >>> bench/cam_register_control_states_tb.sv
// self-checking bench for the register control-state decoder
// assumes the controller model is the only bus master
`timescale 1ns/1ps
module cam_register_control_states_tb
    import crc_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, full_flag_n;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] page_array_addr_out;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;

    crc_core #(.FREE_W(13)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .full_flag_n(full_flag_n),
        .page_array_addr_out(page_array_addr_out));
    crc_ctrl_model m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            $display("CHECK FAILED timeout exp finish got hang");
            close_out();
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // unanswered reads leave the data word as it was, so e is always checked
    task automatic ans(input string n, input logic re, input logic [31:0] e);
        logic [31:0] r;
        m.rd(OFF_RESP, r);
        chk({n, "_resp"}, {31'h0, re}, r);
        m.rd(OFF_DQ_OUT, r);
        chk(n, e, r);
    endtask : ans

    task automatic t_reset;
        chk("pa_out", 32'h0000_FFFF, {16'h0, page_array_addr_out});
        m.rd(OFF_ARRAY, v);
        chk("array", RST_ARRAY, v);
        m.rd(OFF_CASC, v);
        chk("casc", RST_CASC, v);
        m.rd(8'h40, v);
        chk("unmapped", 32'h0000_0000, v);
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask : t_reset

    task automatic t_regs;
        logic [5:0] fns [3] = '{FN_PTR, FN_CFG, FN_CSEL};
        logic [31:0] vals [3] = '{32'hA5A5_0F00, 32'hABCD_1230, 32'h1234_5670};
        for (int i = 0; i < 3; i++) begin
            m.cmd(fns[i], 3'h0, 1'b0, 1'b0, vals[i]);
            m.cmd(fns[i], 3'h0, 1'b1, 1'b0, 32'h0);
            ans("reg", 1'b1, vals[i]);
        end
        m.cmd(FN_NOP_NFA, 3'h1, 1'b0, 1'b0, 32'hFFFF_FFFF);
        m.cmd(FN_STAT, 3'h0, 1'b0, 1'b0, 32'hFFFF_FFFF);
        m.cmd(FN_PTR, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("ptr_kept", 1'b1, vals[0]);
        chk("pa_kept", 32'h0000_FFFF, {16'h0, page_array_addr_out});
    endtask : t_regs

    task automatic t_mask;
        m.cmd(FN_MASK, 3'h1, 1'b0, 1'b0, 32'h0000_FFFF);
        m.cmd(FN_MASK, 3'h1, 1'b0, 1'b1, 32'hFFFF_0000);
        m.cmd(FN_MASK, 3'h0, 1'b0, 1'b0, 32'h1111_1111);
        m.cmd(FN_MASK, 3'h1, 1'b1, 1'b0, 32'h0);
        ans("mask_lo", 1'b1, 32'h0000_FFFF);
        m.cmd(FN_MASK, 3'h1, 1'b1, 1'b1, 32'h0);
        ans("mask_hi", 1'b1, 32'hFFFF_0000);
        m.cmd(FN_MASK, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("mask0", 1'b1, 32'h0000_0000);
        m.cmd(FN_PTR, 3'h1, 1'b0, 1'b0, 32'h1234_5678);
        m.cmd(FN_PTR, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("ptr_masked", 1'b1, 32'h1234_0F00);
        m.cmd(FN_KEY, 3'h0, 1'b0, 1'b0, 32'hC0DE_0001);
        m.cmd(FN_KEY, 3'h0, 1'b0, 1'b1, 32'h8765_4321);
        m.cmd(FN_KEY, 3'h1, 1'b0, 1'b1, 32'h0000_FFFF);
        m.cmd(FN_KEY, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("key_lo", 1'b1, 32'hC0DE_0001);
        m.cmd(FN_KEY, 3'h0, 1'b1, 1'b1, 32'h0);
        ans("key_hi", 1'b1, 32'h8765_FFFF);
    endtask : t_mask

    task automatic t_free;
        m.wr(OFF_ARRAY, 32'h0001_1ABC);
        m.wr(OFF_CASC, 32'h0000_0008);
        m.cmd(FN_CFG, 3'h0, 1'b0, 1'b0, 32'h0000_0005);
        m.cmd(FN_NOP_NFA, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("free", 1'b1, 32'h0005_1ABC);
        m.cmd(FN_PTR, 3'h0, 1'b0, 1'b0, 32'hFFFF_FFFF);
        m.cmd(FN_PTR, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("desel", 1'b0, 32'h0005_1ABC);
        m.cmd(FN_CSEL, 3'h0, 1'b0, 1'b0, 32'h0000_0005);
        m.cmd(FN_PTR, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("sel", 1'b1, 32'h1234_0F00);
        m.wr(OFF_CASC, 32'h0000_0009);
        m.cmd(FN_NOP_NFA, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("free_fi", 1'b0, 32'h1234_0F00);
        m.wr(OFF_ARRAY, 32'h0000_1ABC);
        m.wr(OFF_CASC, 32'h0000_0008);
        chk("full_n", 32'h0, {31'h0, full_flag_n});
        m.cmd(FN_NOP_NFA, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("free_ff", 1'b0, 32'h1234_0F00);
    endtask : t_free

    task automatic t_status;
        logic [31:0] arr [6] = '{32'h000B_0000, 32'h0007_0000,
            32'h0007_0000, 32'h0005_0000, 32'h0005_0000, 32'h0005_0000};
        logic [3:0] casc [6] = '{4'h9, 4'h8, 4'hE, 4'h8, 4'hC, 4'h0};
        logic rs [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        logic [3:0] wd [6] = '{4'h9, 4'h5, 4'h5, 4'h4, 4'h4, 4'h4};
        for (int i = 0; i < 6; i++) begin
            m.wr(OFF_ARRAY, arr[i]);
            m.wr(OFF_CASC, {28'h0, casc[i]});
            m.cmd(FN_STAT, 3'h0, 1'b1, 1'b0, 32'h0);
            ans("status", rs[i], {28'h0, wd[i]});
        end
        // deselect, then a random-access status read must go unanswered
        m.cmd(FN_CSEL, 3'h0, 1'b0, 1'b0, 32'h0000_0000);
        m.wr(OFF_ARRAY, 32'h000B_0000);
        m.cmd(FN_STAT, 3'h0, 1'b1, 1'b0, 32'h0);
        ans("stat_desel", 1'b0, 32'h0000_0004);
    endtask : t_status

    initial begin
        hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_regs();
        t_mask();
        t_free();
        t_status();
        close_out();
    end
endmodule : cam_register_control_states_tb
